// >>> include/swtom_consts.vh
// swtom_consts.vh: offsets, field positions, reset values and widths of the port time-out monitor
// assumes inclusion by bare name from design files under hdl/
`ifndef SWTOM_CONSTS_VH
`define SWTOM_CONSTS_VH

// register byte offsets
`define SWTOM_OFF_ENABLE_CTL 12'h04e4
`define SWTOM_OFF_REPORT_CTL 12'h04e8
`define SWTOM_OFF_DISCARD_CNT 12'h04ec
`define SWTOM_OFF_STATUS 12'h04f0
`define SWTOM_OFF_IRQ_CLEAR 12'h04f4
`define SWTOM_OFF_IRQ_ENABLE 12'h04f8
`define SWTOM_ADDR_W 12

// reset values
`define SWTOM_RST_ENABLE 1'h1
`define SWTOM_RST_REPORT 6'h02
`define SWTOM_RST_COUNT 8'h00

// report selector encodings
`define SWTOM_SEL_NONE 2'h0
`define SWTOM_SEL_COR 2'h1
`define SWTOM_SEL_NONFATAL 2'h2
`define SWTOM_SEL_FATAL 2'h3

// report field positions, class c occupies bits 2c+1:2c
`define SWTOM_REPORT_W 6
// count field positions, class c occupies bits 8c+7:8c
`define SWTOM_COUNT_W 8
`define SWTOM_COUNT_MAX 8'hff

// queue classes: 0 posted, 1 non-posted, 2 completion
`define SWTOM_NCLASS 3
// width of a queue wait age and of the time-out limit
`define SWTOM_AGE_W 16

`endif

// >>> hdl/swtom_sat_counter.v
// swtom_sat_counter.v: one 8-bit saturating discard counter, cleared by a read
// assumes increments and clears arrive synchronous to clk_sys_in
`timescale 1ns/10ps
`default_nettype none
`include "swtom_consts.vh"

module swtom_sat_counter (
  input wire clk_sys_in,
  input wire rst_in,
  input wire inc_in,
  input wire clear_in,
  output reg [`SWTOM_COUNT_W-1:0] count_out
);

  // read clear returns the value first; a discard in the same cycle is kept as one
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      count_out <= `SWTOM_RST_COUNT;
    end else if (clear_in) begin
      count_out <= {{(`SWTOM_COUNT_W-1){1'b0}}, inc_in};
    end else if (inc_in && count_out != `SWTOM_COUNT_MAX) begin
      count_out <= count_out + 8'h01;
    end
  end

endmodule // swtom_sat_counter
`default_nettype wire

// >>> hdl/swtom_report_gen.v
// swtom_report_gen.v: turns a class's status rising edge into a one-cycle error message request
// assumes the message sender takes one request per cycle on each severity line
`timescale 1ns/10ps
`default_nettype none
`include "swtom_consts.vh"

module swtom_report_gen (
  input wire clk_sys_in,
  input wire rst_in,
  input wire status_in,
  input wire [1:0] sel_in,
  output reg msg_cor_out,
  output reg msg_nonfatal_out,
  output reg msg_fatal_out
);

  reg status_prev;
  wire rise;

  // only a zero to one change reports
  assign rise = status_in & ~status_prev;

  // encode the selector into one message pulse
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      status_prev <= 1'b0;
      msg_cor_out <= 1'b0;
      msg_nonfatal_out <= 1'b0;
      msg_fatal_out <= 1'b0;
    end else begin
      status_prev <= status_in;
      msg_cor_out <= rise && sel_in == `SWTOM_SEL_COR;
      msg_nonfatal_out <= rise && sel_in == `SWTOM_SEL_NONFATAL;
      msg_fatal_out <= rise && sel_in == `SWTOM_SEL_FATAL;
    end
  end

endmodule // swtom_report_gen
`default_nettype wire

// >>> hdl/swtom_monitor.v
// swtom_monitor.v: ingress queue time-out monitor of one switch port with its register bank
// assumes a synchronous register port with read data one cycle after the read strobe,
// and a queue that reports the head packet's wait age per class and drops on request
`timescale 1ns/10ps
`default_nettype none
`include "swtom_consts.vh"

module swtom_monitor (
  input wire clk_sys_in,
  input wire rst_in,
  input wire sticky_rst_in,
  input wire [`SWTOM_ADDR_W-1:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  input wire [`SWTOM_AGE_W-1:0] timeout_limit_in,
  input wire [`SWTOM_NCLASS-1:0] head_valid_in,
  input wire [`SWTOM_NCLASS*`SWTOM_AGE_W-1:0] head_age_in,
  output reg [`SWTOM_NCLASS-1:0] discard_out,
  output reg [`SWTOM_NCLASS-1:0] timeout_status_out,
  output reg msg_cor_out,
  output reg msg_nonfatal_out,
  output reg msg_fatal_out,
  output reg irq_out
);

  // sticky control state
  reg timeout_discard_enable;
  reg [`SWTOM_REPORT_W-1:0] report_sel;
  // status, interrupt state
  reg [`SWTOM_NCLASS-1:0] timeout_status_reg;
  reg [`SWTOM_NCLASS-1:0] irq_enable;
  reg [31:0] next_rdata;
  wire [`SWTOM_NCLASS-1:0] drop;
  wire [`SWTOM_NCLASS*`SWTOM_COUNT_W-1:0] counts;
  wire [`SWTOM_NCLASS-1:0] msg_cor;
  wire [`SWTOM_NCLASS-1:0] msg_nonfatal;
  wire [`SWTOM_NCLASS-1:0] msg_fatal;
  wire [`SWTOM_NCLASS-1:0] status_clr;
  wire cnt_rd;
  wire sel_enable;
  wire sel_report;
  wire sel_clear;
  wire sel_irq_en;

  assign sel_enable = reg_addr_in == `SWTOM_OFF_ENABLE_CTL;
  assign sel_report = reg_addr_in == `SWTOM_OFF_REPORT_CTL;
  assign sel_clear = reg_addr_in == `SWTOM_OFF_IRQ_CLEAR;
  assign sel_irq_en = reg_addr_in == `SWTOM_OFF_IRQ_ENABLE;
  assign cnt_rd = reg_rd_in && reg_addr_in == `SWTOM_OFF_DISCARD_CNT;
  assign status_clr = (reg_wr_in && sel_clear) ? reg_wdata_in[`SWTOM_NCLASS-1:0] : {`SWTOM_NCLASS{1'b0}};

  // per-class drop decision, counter and report generator
  genvar c;
  generate
    for (c = 0; c < `SWTOM_NCLASS; c = c + 1) begin : g_class
      // head packet waited beyond the limit while enabled
      assign drop[c] = timeout_discard_enable && head_valid_in[c] &&
        head_age_in[c*`SWTOM_AGE_W +: `SWTOM_AGE_W] > timeout_limit_in;

      // discard count of this class
      swtom_sat_counter u_count (
        .clk_sys_in(clk_sys_in),
        .rst_in(sticky_rst_in),
        .inc_in(drop[c]),
        .clear_in(cnt_rd),
        .count_out(counts[c*`SWTOM_COUNT_W +: `SWTOM_COUNT_W])
      );

      // message request on status rise
      swtom_report_gen u_report (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .status_in(timeout_status_reg[c]),
        .sel_in(report_sel[2*c +: 2]),
        .msg_cor_out(msg_cor[c]),
        .msg_nonfatal_out(msg_nonfatal[c]),
        .msg_fatal_out(msg_fatal[c])
      );
    end
  endgenerate

  // sticky control registers, held across the ordinary reset
  always @(posedge clk_sys_in) begin
    if (sticky_rst_in) begin
      timeout_discard_enable <= `SWTOM_RST_ENABLE;
      report_sel <= `SWTOM_RST_REPORT;
    end else if (reg_wr_in) begin
      if (sel_enable) begin
        timeout_discard_enable <= reg_wdata_in[0];
      end
      if (sel_report) begin
        report_sel <= reg_wdata_in[`SWTOM_REPORT_W-1:0];
      end
    end
  end

  // status bits set by a discard; set wins over a write-one clear
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      timeout_status_reg <= {`SWTOM_NCLASS{1'b0}};
      irq_enable <= {`SWTOM_NCLASS{1'b0}};
    end else begin
      timeout_status_reg <= (timeout_status_reg & ~status_clr) | drop;
      if (reg_wr_in && sel_irq_en) begin
        irq_enable <= reg_wdata_in[`SWTOM_NCLASS-1:0];
      end
    end
  end

  // read data mux; reserved bits and unmapped addresses read zero
  always @* begin
    next_rdata = 32'h0000_0000;
    case (reg_addr_in)
      `SWTOM_OFF_ENABLE_CTL: next_rdata[0] = timeout_discard_enable;
      `SWTOM_OFF_REPORT_CTL: next_rdata[`SWTOM_REPORT_W-1:0] = report_sel;
      `SWTOM_OFF_DISCARD_CNT: next_rdata[23:0] = counts;
      `SWTOM_OFF_STATUS: next_rdata[`SWTOM_NCLASS-1:0] = timeout_status_reg;
      `SWTOM_OFF_IRQ_ENABLE: next_rdata[`SWTOM_NCLASS-1:0] = irq_enable;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // registered outputs
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
      discard_out <= {`SWTOM_NCLASS{1'b0}};
      timeout_status_out <= {`SWTOM_NCLASS{1'b0}};
      msg_cor_out <= 1'b0;
      msg_nonfatal_out <= 1'b0;
      msg_fatal_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_rd_in ? next_rdata : 32'h0000_0000;
      discard_out <= drop;
      timeout_status_out <= timeout_status_reg;
      msg_cor_out <= |msg_cor;
      msg_nonfatal_out <= |msg_nonfatal;
      msg_fatal_out <= |msg_fatal;
      irq_out <= |(timeout_status_reg & irq_enable);
    end
  end

endmodule // swtom_monitor
`default_nettype wire

// >>> dv/swtom_root_model.sv
// swtom_root_model.sv: root complex stand-in, counts error messages
// assumes one-cycle message pulses synchronous to clk_sys_in
`timescale 1ns/10ps
`default_nettype none
module swtom_root_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic msg_cor_in,
  input wire logic msg_nonfatal_in,
  input wire logic msg_fatal_in,
  output logic [23:0] msg_count_out
);
  // one count byte per severity: fatal, nonfatal, correctable
  always @(posedge clk_sys_in) begin
    if (rst_in) msg_count_out <= 24'h00_0000;
    else msg_count_out <= msg_count_out + {7'h0, msg_fatal_in, 7'h0, msg_nonfatal_in, 7'h0, msg_cor_in};
  end
endmodule // swtom_root_model
`default_nettype wire

// >>> dv/swtom_chk_monitor.sv
// swtom_chk_monitor.sv: port assertions of the time-out monitor
// assumes one clock, rst_in synchronous active high
`timescale 1ns/10ps
`default_nettype none
module swtom_chk (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [15:0] timeout_limit_in,
  input wire logic [2:0] head_valid_in,
  input wire logic [47:0] head_age_in,
  input wire logic [2:0] discard_out,
  input wire logic [2:0] timeout_status_out,
  input wire logic msg_cor_out,
  input wire logic msg_nonfatal_out,
  input wire logic msg_fatal_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // count read and a cycle with no drop
  sequence s_rd_cnt;
    reg_rd_in && reg_addr_in == 12'h04ec;
  endsequence
  sequence s_quiet;
    discard_out == 3'h0;
  endsequence
  // register port, drop path, reports
  chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside read slot");
  chk_cnt_upper: assert property ($past(reg_rd_in) |-> reg_rdata_out[31:24] == 8'h00)
    else $error("upper byte not zero");
  chk_drop_cause: assert property (discard_out[0] |-> $past(head_valid_in[0] && head_age_in[15:0] > timeout_limit_in))
    else $error("drop without time-out");
  chk_young_kept: assert property (!(head_valid_in[1] && head_age_in[31:16] > timeout_limit_in) |=> !discard_out[1])
    else $error("young packet dropped");
  chk_status_set: assert property (discard_out[2] |=> timeout_status_out[2])
    else $error("status not set by drop");
  chk_report_edge: assert property ((msg_cor_out || msg_nonfatal_out || msg_fatal_out) |->
    |($past(timeout_status_out) & ~$past(timeout_status_out, 2))) else $error("report without rise");
  chk_irq_cause: assert property (irq_out |-> timeout_status_out != 3'h0)
    else $error("irq without status");
  chk_read_clear: assert property (s_rd_cnt ##1 s_quiet ##1 (s_rd_cnt and s_quiet) |=> reg_rdata_out == 32'h0)
    else $error("count not cleared by read");
endmodule // swtom_chk
bind swtom_monitor swtom_chk u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .timeout_limit_in(timeout_limit_in),
  .head_valid_in(head_valid_in), .head_age_in(head_age_in), .discard_out(discard_out),
  .timeout_status_out(timeout_status_out), .msg_cor_out(msg_cor_out), .msg_nonfatal_out(msg_nonfatal_out),
  .msg_fatal_out(msg_fatal_out), .irq_out(irq_out));
`default_nettype wire

// >>> dv/swtom_monitor_tb.sv
// swtom_monitor_tb.sv: register and drop scenarios of the time-out monitor
// assumes the design under hdl/ and the root model beside it
`timescale 1ns/10ps
`default_nettype none
module swtom_monitor_tb;
  logic clk_sys_in = 0, rst_in = 1, sticky_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, c, n, f, irq;
  logic [11:0] reg_addr_in = 12'h0000;
  logic [31:0] reg_wdata_in = 32'h0000_0000, rdata;
  logic [2:0] hv = 3'h0;
  logic [47:0] age = 48'h0000_0000_0000;
  logic [23:0] msgs;
  int n_mismatch = 0, checked = 0;
  // 50 MHz clock
  always #10 clk_sys_in = ~clk_sys_in;
  swtom_monitor dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sticky_rst_in(sticky_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata), .timeout_limit_in(16'h0010), .head_valid_in(hv), .head_age_in(age),
    .discard_out(), .timeout_status_out(), .msg_cor_out(c), .msg_nonfatal_out(n), .msg_fatal_out(f), .irq_out(irq));
  swtom_root_model root (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .msg_cor_in(c), .msg_nonfatal_in(n),
    .msg_fatal_in(f), .msg_count_out(msgs));
  // compare and register access, w=0 reads and compares with d
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= w;
    reg_rd_in <= !w;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    {reg_wr_in, reg_rd_in} <= 2'h0;
    #1 if (!w) chk(rdata, d);
  endtask
  // queue head of class q stays valid at age a for k cycles
  task drop(input int q, input int k, input logic [15:0] a);
    @(posedge clk_sys_in);
    hv[q] <= 1'h1;
    age[q*16 +: 16] <= a;
    repeat (k) @(posedge clk_sys_in);
    hv[q] <= 1'h0;
    repeat (5) @(posedge clk_sys_in);
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog, the sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    n_mismatch++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys_in);
    {rst_in, sticky_rst_in} <= 2'h0;
    acc(0, 12'h04e4, 32'h0000_0001);
    acc(0, 12'h04e8, 32'h0000_0002);
    acc(0, 12'h04e0, 32'h0000_0000);
    acc(1, 12'h04e4, 32'hffff_fffe);
    acc(0, 12'h04e4, 32'h0000_0000);
    acc(1, 12'h04e8, 32'hffff_fff9);
    acc(0, 12'h04e8, 32'h0000_0039);
    drop(0, 4, 16'h0010);
    drop(0, 3, 16'h0011);
    acc(1, 12'h04e4, 32'h0000_0001);
    drop(0, 3, 16'h0011);
    drop(1, 5, 16'hffff);
    drop(2, 1, 16'h0011);
    acc(0, 12'h04f0, 32'h0000_0007);
    chk({8'h00, msgs}, 32'h0001_0101);
    acc(0, 12'h04ec, 32'h0001_0503);
    acc(0, 12'h04ec, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    acc(1, 12'h04f8, 32'h0000_0007);
    // irq output is registered one edge after the enable write lands
    @(posedge clk_sys_in);
    #1 chk({31'h0, irq}, 32'h0000_0001);
    acc(1, 12'h04f4, 32'h0000_0007);
    acc(1, 12'h04e8, 32'h0000_0001);
    @(posedge clk_sys_in);
    #1 chk({31'h0, irq}, 32'h0000_0000);
    drop(0, 1, 16'h0011);
    drop(1, 1, 16'h0011);
    chk({8'h00, msgs}, 32'h0001_0102);
    drop(2, 300, 16'h0011);
    acc(0, 12'h04ec, 32'h00ff_0101);
    @(posedge clk_sys_in);
    rst_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    acc(0, 12'h04e8, 32'h0000_0001);
    end_of_test;
  end
endmodule // swtom_monitor_tb
`default_nettype wire
